// ### rtl/sph_device.sv
// Notes on behaviour
// - scanning channel tolerance fixed at 1000 increments
// - deviation judged on native 13-bit resolution
// - host writes safety parameters at start-up
// - watchdog default 125 ms, range 10-10000
// - source address default 1, range 1-65534
// - destination address default 1, range 1-255
// - block identifier 1 demands parameter CRC
// - parameter CRC is full 32-bit unsigned
// - preset value becomes the output position
// - host presets only during cyclic exchange
// - host checks enable and clear acknowledges first
// - host loads preset value before triggering
// - control bit 0 acknowledged by status bit 2
// - trigger rising edge checks prerequisites first
// - success loads position, sets status bit 6
// - failure keeps position, sets status bit 5
// - trigger cleared, device clears status bit 6
// - activation cleared, device clears status bit 2
// - host verifies position equals preset
// - safety and standard alarms on separate channels
// - shared faults reported on both channels
// - channel diagnosis, up to four relationships
`timescale 1ns/1ns
module sph_device (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // link to the safety host
  sph_link_if.device       link,
  // scanning channels, native resolution
  input  wire logic [31:0] master_position,
  input  wire logic [31:0] slave_position,
  // configuration
  input  wire logic        preset_enable,
  input  wire logic [31:0] measuring_range,
  input  wire logic [3:0]  relation_active,
  // diagnostics
  input  wire logic        fault_safety_only,
  input  wire logic        fault_shared,
  input  wire logic        fault_standard_only,
  output logic             deviation_fault,
  output logic [3:0]       safety_alarm,
  output logic             standard_alarm,
  output logic [31:0]      param_crc_in_use,
  output logic [15:0]      watchdog_ms
);

  function automatic logic [31:0] abs_diff(input logic [31:0] a, input logic [31:0] b);
    abs_diff = (a > b) ? a - b : b - a;
  endfunction

  logic        trig_q;
  logic        act_ack;
  logic        trig_ack;
  logic        preset_err;
  logic [31:0] offset;
  logic [31:0] next_position;
  logic        trig_rise;
  logic        prereq_ok;
  logic        params_ok;
  logic [31:0] raw_in_range;

  assign trig_rise = link.safety_control_word[sph_pkg::CTRL_TRIGGER_BIT] & ~trig_q;
  assign raw_in_range = master_position % measuring_range;
  // a trigger without an acknowledged activation counts as a failed prerequisite
  assign prereq_ok = act_ack & preset_enable & link.cyclic_exchange
                     & (link.safety_preset_value < measuring_range);

  // raw position plus preset offset, wrapped into the scaled range
  always_comb
  begin
    next_position = master_position + offset;
    if (next_position >= measuring_range)
    begin
      next_position = next_position - measuring_range;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      trig_q <= 1'b0;
    end
    else
    begin
      trig_q <= link.safety_control_word[sph_pkg::CTRL_TRIGGER_BIT];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      act_ack <= 1'b0;
    end
    else
    begin
      act_ack <= link.safety_control_word[sph_pkg::CTRL_ACTIVATE_BIT];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      trig_ack   <= 1'b0;
      preset_err <= 1'b0;
      offset     <= 32'h0000_0000;
    end
    else if (trig_rise)
    begin
      if (prereq_ok)
      begin
        // offset chosen so the current raw value now reads as the preset
        offset     <= (link.safety_preset_value >= raw_in_range)
                      ? link.safety_preset_value - raw_in_range
                      : link.safety_preset_value + measuring_range - raw_in_range;
        trig_ack   <= 1'b1;
        preset_err <= 1'b0;
      end
      else
      begin
        preset_err <= 1'b1;
      end
    end
    else if (!link.safety_control_word[sph_pkg::CTRL_TRIGGER_BIT])
    begin
      trig_ack <= 1'b0;
      if (!link.safety_control_word[sph_pkg::CTRL_ACTIVATE_BIT])
      begin
        preset_err <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      link.safety_status_word <= sph_pkg::STATUS_RESET;
      link.safety_position_32 <= 32'h0000_0000;
    end
    else
    begin
      link.safety_status_word <= sph_pkg::STATUS_RESET;
      link.safety_status_word[sph_pkg::STAT_ACT_ACK_BIT]  <= act_ack;
      link.safety_status_word[sph_pkg::STAT_TRIG_ACK_BIT] <= trig_ack;
      link.safety_status_word[sph_pkg::STAT_ERROR_BIT]    <= preset_err;
      link.safety_position_32 <= next_position;
    end
  end

  // channel values arrive in native units, so scaling never enters this comparison
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      deviation_fault <= 1'b0;
    end
    else
    begin
      deviation_fault <= abs_diff(master_position, slave_position)
                         > sph_pkg::WINDOW_INCREMENTS;
    end
  end

  assign params_ok = (link.safety_watchdog_time >= sph_pkg::WATCHDOG_MIN_MS)
                   & (link.safety_watchdog_time <= sph_pkg::WATCHDOG_MAX_MS)
                   & (link.source_address >= sph_pkg::SOURCE_ADDR_MIN)
                   & (link.source_address <= sph_pkg::SOURCE_ADDR_MAX)
                   & (link.dest_address >= sph_pkg::DEST_ADDR_MIN)
                   & ((link.parameter_block_identifier != sph_pkg::BLOCK_ID_USES_CRC)
                      | link.crc_supplied);

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      watchdog_ms          <= sph_pkg::WATCHDOG_DEFAULT_MS;
      param_crc_in_use     <= 32'h0000_0000;
      link.param_accepted  <= 1'b0;
      link.param_rejected  <= 1'b0;
      link.cyclic_exchange <= 1'b0;
    end
    else
    begin
      link.param_accepted <= 1'b0;
      link.param_rejected <= 1'b0;
      if (link.param_write)
      begin
        if (params_ok)
        begin
          watchdog_ms          <= link.safety_watchdog_time;
          param_crc_in_use     <= (link.parameter_block_identifier == sph_pkg::BLOCK_ID_USES_CRC)
                                  ? link.individual_parameter_crc : 32'h0000_0000;
          link.param_accepted  <= 1'b1;
          link.cyclic_exchange <= 1'b1;
        end
        else
        begin
          link.param_rejected  <= 1'b1;
          link.cyclic_exchange <= 1'b0;
        end
      end
    end
  end

  // each relationship gets its own safety channel; shared faults also hit the standard one
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      safety_alarm   <= 4'h0;
      standard_alarm <= 1'b0;
    end
    else
    begin
      safety_alarm   <= relation_active
                        & {sph_pkg::ALARM_CHANNELS{fault_safety_only | fault_shared | deviation_fault}};
      standard_alarm <= fault_standard_only | fault_shared;
    end
  end

endmodule

// ### rtl/sph_pkg.sv
package sph_pkg;

  // safety control word bits
  localparam int CTRL_ACTIVATE_BIT = 0;
  localparam int CTRL_TRIGGER_BIT  = 6;
  // safety status word bits
  localparam int STAT_ACT_ACK_BIT  = 2;
  localparam int STAT_ERROR_BIT    = 5;
  localparam int STAT_TRIG_ACK_BIT = 6;

  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // scanning channel comparison
  localparam int          NATIVE_BITS       = 13;
  localparam logic [31:0] NATIVE_STEPS      = 32'h0000_2000;
  localparam logic [31:0] WINDOW_INCREMENTS = 32'h0000_03E8;

  // start-up parameter set defaults and ranges
  localparam logic [15:0] WATCHDOG_DEFAULT_MS = 16'h007D;
  localparam logic [15:0] WATCHDOG_MIN_MS     = 16'h000A;
  localparam logic [15:0] WATCHDOG_MAX_MS     = 16'h2710;
  localparam logic [15:0] SOURCE_ADDR_DEFAULT = 16'h0001;
  localparam logic [15:0] SOURCE_ADDR_MIN     = 16'h0001;
  localparam logic [15:0] SOURCE_ADDR_MAX     = 16'hFFFE;
  localparam logic [7:0]  DEST_ADDR_DEFAULT   = 8'h01;
  localparam logic [7:0]  DEST_ADDR_MIN       = 8'h01;
  localparam logic [7:0]  DEST_ADDR_MAX       = 8'hFF;
  localparam logic [7:0]  BLOCK_ID_USES_CRC   = 8'h01;
  localparam logic [15:0] PARAM_RECORD_INDEX  = 16'h0002;

  localparam int ALARM_CHANNELS = 4;

endpackage

// ### rtl/sph_link_if.sv
`timescale 1ns/1ns
interface sph_link_if;
  logic [15:0] safety_control_word;
  logic [31:0] safety_preset_value;
  logic [15:0] safety_status_word;
  logic [31:0] safety_position_32;
  logic        param_write;
  logic [15:0] safety_watchdog_time;
  logic [15:0] source_address;
  logic [7:0]  dest_address;
  logic [7:0]  parameter_block_identifier;
  logic [31:0] individual_parameter_crc;
  logic        crc_supplied;
  logic        param_accepted;
  logic        param_rejected;
  logic        cyclic_exchange;

  modport device (
    input  safety_control_word, safety_preset_value, param_write, safety_watchdog_time,
           source_address, dest_address, parameter_block_identifier,
           individual_parameter_crc, crc_supplied,
    output safety_status_word, safety_position_32, param_accepted, param_rejected, cyclic_exchange
  );
  modport host (
    output safety_control_word, safety_preset_value, param_write, safety_watchdog_time,
           source_address, dest_address, parameter_block_identifier,
           individual_parameter_crc, crc_supplied,
    input  safety_status_word, safety_position_32, param_accepted, param_rejected, cyclic_exchange
  );
endinterface

// ### rtl/sph_host.sv
`timescale 1ns/1ns
module sph_host (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // link to the encoder
  sph_link_if.host         link,
  // user command side
  input  wire logic        start_params,
  input  wire logic [15:0] cfg_watchdog_ms,
  input  wire logic [15:0] cfg_source_addr,
  input  wire logic [7:0]  cfg_dest_addr,
  input  wire logic [7:0]  cfg_block_id,
  input  wire logic [31:0] cfg_crc,
  input  wire logic        preset_request,
  input  wire logic [31:0] preset_target,
  input  wire logic        preset_enabled,
  output logic             busy,
  output logic             preset_done,
  output logic             preset_failed
);

  typedef enum {IDLE, ACTIVATE, TRIGGER, RELEASE_TRIG, DEACTIVATE, VERIFY} sph_state_type;
  sph_state_type state;
  logic [31:0]   target;
  logic          failed;

  // parameter record written once per request, held otherwise
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      link.param_write                <= 1'b0;
      link.safety_watchdog_time       <= sph_pkg::WATCHDOG_DEFAULT_MS;
      link.source_address             <= sph_pkg::SOURCE_ADDR_DEFAULT;
      link.dest_address               <= sph_pkg::DEST_ADDR_DEFAULT;
      link.parameter_block_identifier <= sph_pkg::BLOCK_ID_USES_CRC;
      link.individual_parameter_crc   <= 32'h0000_0000;
      link.crc_supplied               <= 1'b0;
    end
    else
    begin
      link.param_write <= start_params;
      if (start_params)
      begin
        link.safety_watchdog_time       <= cfg_watchdog_ms;
        link.source_address             <= cfg_source_addr;
        link.dest_address               <= cfg_dest_addr;
        link.parameter_block_identifier <= cfg_block_id;
        link.individual_parameter_crc   <= cfg_crc;
        link.crc_supplied               <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      state                    <= IDLE;
      target                   <= 32'h0000_0000;
      failed                   <= 1'b0;
      link.safety_control_word <= 16'h0000;
      link.safety_preset_value <= 32'h0000_0000;
      busy                     <= 1'b0;
      preset_done              <= 1'b0;
      preset_failed            <= 1'b0;
    end
    else
    begin
      preset_done   <= 1'b0;
      preset_failed <= 1'b0;
      case (state)
        IDLE:
        begin
          busy <= 1'b0;
          if (preset_request & preset_enabled & link.cyclic_exchange
              & ~link.safety_status_word[sph_pkg::STAT_ACT_ACK_BIT]
              & ~link.safety_status_word[sph_pkg::STAT_TRIG_ACK_BIT])
          begin
            busy                     <= 1'b1;
            failed                   <= 1'b0;
            target                   <= preset_target;
            link.safety_preset_value <= preset_target;
            link.safety_control_word[sph_pkg::CTRL_ACTIVATE_BIT] <= 1'b1;
            state                    <= ACTIVATE;
          end
        end
        ACTIVATE:
          if (link.safety_status_word[sph_pkg::STAT_ACT_ACK_BIT])
          begin
            link.safety_control_word[sph_pkg::CTRL_TRIGGER_BIT] <= 1'b1;
            state <= TRIGGER;
          end
        TRIGGER:
          if (link.safety_status_word[sph_pkg::STAT_TRIG_ACK_BIT]
              | link.safety_status_word[sph_pkg::STAT_ERROR_BIT])
          begin
            failed <= link.safety_status_word[sph_pkg::STAT_ERROR_BIT];
            link.safety_control_word[sph_pkg::CTRL_TRIGGER_BIT] <= 1'b0;
            state <= RELEASE_TRIG;
          end
        RELEASE_TRIG:
          if (!link.safety_status_word[sph_pkg::STAT_TRIG_ACK_BIT])
          begin
            link.safety_control_word[sph_pkg::CTRL_ACTIVATE_BIT] <= 1'b0;
            state <= DEACTIVATE;
          end
        DEACTIVATE:
          if (!link.safety_status_word[sph_pkg::STAT_ACT_ACK_BIT])
          begin
            state <= VERIFY;
          end
        VERIFY:
        begin
          // position moves with the shaft; comparison is only exact on a still shaft
          preset_done   <= 1'b1;
          preset_failed <= failed | (link.safety_position_32 != target);
          busy          <= 1'b0;
          state         <= IDLE;
        end
        default:
          state <= IDLE;
      endcase
    end
  end

endmodule

// ### verif/sph_link_chk.sv
`timescale 1ns/1ns
module sph_link_chk (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst_b,
  // host to device
  input wire logic [15:0] safety_control_word,
  input wire logic [31:0] safety_preset_value,
  input wire logic        param_write,
  input wire logic [15:0] safety_watchdog_time,
  input wire logic [15:0] source_address,
  input wire logic [7:0]  dest_address,
  input wire logic [7:0]  parameter_block_identifier,
  input wire logic        crc_supplied,
  // device to host
  input wire logic [15:0] safety_status_word,
  input wire logic [31:0] safety_position_32,
  input wire logic        param_accepted,
  input wire logic        param_rejected,
  input wire logic        cyclic_exchange
);
  wire [15:0] ctl = safety_control_word;
  wire [15:0] sts = safety_status_word;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_trig_edge;
    $rose(ctl[6]);
  endsequence
  sequence s_trig_answer;
    ##2 (sts[6] || sts[5]);
  endsequence
  property p_act_ack;
    $rose(ctl[0]) |-> ##2 sts[2];
  endproperty
  a_act_ack: assert property (p_act_ack) else $error("activate ack late");
  property p_act_clear;
    $fell(ctl[0]) |-> ##2 !sts[2];
  endproperty
  a_act_clear: assert property (p_act_clear) else $error("activate ack stuck");
  property p_trig_answer;
    s_trig_edge |-> s_trig_answer;
  endproperty
  a_trig_answer: assert property (p_trig_answer) else $error("trigger unanswered");
  property p_trig_pos;
    $rose(sts[6]) |-> safety_position_32 == safety_preset_value;
  endproperty
  a_trig_pos: assert property (p_trig_pos) else $error("position not preset");
  property p_trig_clear;
    $fell(ctl[6]) |-> ##2 !sts[6];
  endproperty
  a_trig_clear: assert property (p_trig_clear) else $error("trigger ack stuck");
  property p_err_keep;
    $rose(sts[5]) |-> !sts[6] && $stable(safety_position_32);
  endproperty
  a_err_keep: assert property (p_err_keep) else $error("rejected preset moved position");
  property p_param_answer;
    param_write |=> param_accepted != param_rejected;
  endproperty
  a_param_answer: assert property (p_param_answer) else $error("parameter write unanswered");
  property p_wd_range;
    param_write && (safety_watchdog_time < sph_pkg::WATCHDOG_MIN_MS || safety_watchdog_time > sph_pkg::WATCHDOG_MAX_MS)
      |=> param_rejected && !cyclic_exchange;
  endproperty
  a_wd_range: assert property (p_wd_range) else $error("bad watchdog accepted");
  property p_addr_range;
    param_write && (source_address == 16'h0000 || source_address == 16'hFFFF || dest_address == 8'h00)
      |=> param_rejected;
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("bad address accepted");
  property p_crc_need;
    param_write && parameter_block_identifier == sph_pkg::BLOCK_ID_USES_CRC && !crc_supplied |=> param_rejected;
  endproperty
  a_crc_need: assert property (p_crc_need) else $error("missing crc accepted");
endmodule

// ### verif/safety_preset_handshake_bench.sv
`timescale 1ns/1ns
`define CHECK(what, exp, got) begin checked++; if ((got) !== (exp)) begin fails++; \
  $display("wrong value %s expected %0h seen %0h", what, exp, got); end end
module safety_preset_handshake_bench;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic [31:0] master_position = 32'h0000_5000;
  logic [31:0] slave_position = 32'h0000_5000;
  logic        preset_enable = 1'b1;
  logic [31:0] measuring_range = 32'h0001_0000;
  logic [3:0]  relation_active = 4'hA;
  logic        fault_safety_only = 1'b0;
  logic        fault_shared = 1'b0;
  logic        fault_standard_only = 1'b0;
  logic        deviation_fault, standard_alarm;
  logic [3:0]  safety_alarm;
  logic [15:0] watchdog_ms, rogue_wd;
  logic [31:0] rogue_crc;
  logic        start_params = 1'b0;
  logic [15:0] cfg_watchdog_ms = 16'h0000;
  logic [15:0] cfg_source_addr = 16'h0000;
  logic [7:0]  cfg_dest_addr = 8'h00;
  logic [7:0]  cfg_block_id = 8'h00;
  logic [31:0] cfg_crc = 32'h89AB_CDEF;
  logic        preset_request = 1'b0;
  logic [31:0] preset_target = 32'h0000_0000;
  logic        preset_enabled = 1'b1;
  logic        busy, preset_done, preset_failed;
  logic [15:0] t_ctl [9] = '{16'h0040, 16'h0000, 16'h0001, 16'h0041, 16'h0000, 16'h0001, 16'h0041, 16'h0001, 16'h0000};
  logic [15:0] t_sts [9] = '{16'h0020, 16'h0000, 16'h0004, 16'h0024, 16'h0000, 16'h0004, 16'h0044, 16'h0004, 16'h0000};
  int          fails = 0;
  int          checked = 0;
  always #10 clock = ~clock;
  sph_link_if link ();
  // second link: the bench plays a host that breaks the handshake on purpose
  sph_link_if rogue ();
  sph_device u_sph_device (.clock(clock), .rst_b(rst_b), .link(link), .master_position(master_position),
    .slave_position(slave_position), .preset_enable(preset_enable), .measuring_range(measuring_range),
    .relation_active(relation_active), .fault_safety_only(fault_safety_only), .fault_shared(fault_shared),
    .fault_standard_only(fault_standard_only), .deviation_fault(deviation_fault), .safety_alarm(safety_alarm),
    .standard_alarm(standard_alarm), .param_crc_in_use(), .watchdog_ms(watchdog_ms));
  sph_device u_sph_device_rogue (.clock(clock), .rst_b(rst_b), .link(rogue), .master_position(master_position),
    .slave_position(slave_position), .preset_enable(preset_enable), .measuring_range(measuring_range),
    .relation_active(relation_active), .fault_safety_only(fault_safety_only), .fault_shared(fault_shared),
    .fault_standard_only(fault_standard_only), .deviation_fault(), .safety_alarm(), .standard_alarm(),
    .param_crc_in_use(rogue_crc), .watchdog_ms(rogue_wd));
  sph_host u_sph_host (.clock(clock), .rst_b(rst_b), .link(link), .start_params(start_params),
    .cfg_watchdog_ms(cfg_watchdog_ms), .cfg_source_addr(cfg_source_addr), .cfg_dest_addr(cfg_dest_addr),
    .cfg_block_id(cfg_block_id), .cfg_crc(cfg_crc), .preset_request(preset_request), .preset_target(preset_target),
    .preset_enabled(preset_enabled), .busy(busy), .preset_done(preset_done), .preset_failed(preset_failed));
  sph_link_chk u_sph_link_chk (.clock(clock), .rst_b(rst_b), .safety_control_word(link.safety_control_word),
    .safety_preset_value(link.safety_preset_value), .param_write(link.param_write),
    .safety_watchdog_time(link.safety_watchdog_time), .source_address(link.source_address),
    .dest_address(link.dest_address), .parameter_block_identifier(link.parameter_block_identifier),
    .crc_supplied(link.crc_supplied), .safety_status_word(link.safety_status_word),
    .safety_position_32(link.safety_position_32), .param_accepted(link.param_accepted),
    .param_rejected(link.param_rejected), .cyclic_exchange(link.cyclic_exchange));
  initial
  begin
    rogue.safety_control_word = 16'h0000;
    rogue.safety_preset_value = 32'h0000_0000;
    rogue.param_write = 1'b0;
    rogue.safety_watchdog_time = 16'h007D;
    rogue.source_address = 16'h0001;
    rogue.dest_address = 8'h01;
    rogue.parameter_block_identifier = 8'h00;
    rogue.individual_parameter_crc = 32'h0000_0000;
    rogue.crc_supplied = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic rogue_param(input logic [15:0] wd, src, input logic [7:0] dst, blk, input logic [31:0] crc,
                             input logic sup, acc);
    rogue.safety_watchdog_time = wd;
    rogue.source_address = src;
    rogue.dest_address = dst;
    rogue.parameter_block_identifier = blk;
    rogue.individual_parameter_crc = crc;
    rogue.crc_supplied = sup;
    rogue.param_write = 1'b1;
    step(1);
    rogue.param_write = 1'b0;
    `CHECK("rogue param accepted", acc, rogue.param_accepted)
    if (acc)
      `CHECK("rogue watchdog", wd, rogue_wd)
    step(1);
  endtask
  task automatic host_param(input logic [15:0] wd, src, input logic [7:0] dst, blk, input logic acc);
    int i;
    cfg_watchdog_ms = wd;
    cfg_source_addr = src;
    cfg_dest_addr = dst;
    cfg_block_id = blk;
    start_params = 1'b1;
    step(1);
    start_params = 1'b0;
    for (i = 0; i < 40 && link.param_accepted !== 1'b1 && link.param_rejected !== 1'b1; i++)
      step(1);
    `CHECK("host param accepted", acc, link.param_accepted)
    `CHECK("host param rejected", !acc, link.param_rejected)
    step(2);
  endtask
  task automatic run_preset(input logic [31:0] target, input logic fail);
    int i;
    preset_target = target;
    preset_request = 1'b1;
    step(1);
    preset_request = 1'b0;
    `CHECK("host busy", 1'b1, busy)
    for (i = 0; i < 60 && preset_done !== 1'b1; i++)
      step(1);
    `CHECK("preset done", 1'b1, preset_done)
    `CHECK("preset failed", fail, preset_failed)
    `CHECK("host idle", 1'b0, busy)
    step(2);
  endtask
  initial
  begin
    int          i;
    logic [31:0] exp_pos;
    step(4);
    rst_b = 1'b1;
    `CHECK("default watchdog", 16'h007D, rogue_wd)
    rogue_param(16'h000A, 16'h0001, 8'h01, 8'h00, 32'h0, 1'b0, 1'b1);
    rogue_param(16'h0009, 16'h0001, 8'h01, 8'h00, 32'h0, 1'b0, 1'b0);
    `CHECK("exchange after reject", 1'b0, rogue.cyclic_exchange)
    rogue_param(16'h2710, 16'h0001, 8'h01, 8'h00, 32'h0, 1'b0, 1'b1);
    rogue_param(16'h2711, 16'h0001, 8'h01, 8'h00, 32'h0, 1'b0, 1'b0);
    rogue_param(16'h007D, 16'h0000, 8'h01, 8'h00, 32'h0, 1'b0, 1'b0);
    rogue_param(16'h007D, 16'hFFFE, 8'h01, 8'h00, 32'h0, 1'b0, 1'b1);
    rogue_param(16'h007D, 16'hFFFF, 8'h01, 8'h00, 32'h0, 1'b0, 1'b0);
    rogue_param(16'h007D, 16'h0001, 8'h00, 8'h00, 32'h0, 1'b0, 1'b0);
    rogue_param(16'h007D, 16'h0001, 8'hFF, 8'h00, 32'h0, 1'b0, 1'b1);
    rogue_param(16'h007D, 16'h0001, 8'h01, 8'h01, 32'hFFFF_FFFF, 1'b0, 1'b0);
    rogue_param(16'h007D, 16'h0001, 8'h01, 8'h01, 32'hFFFF_FFFF, 1'b1, 1'b1);
    `CHECK("crc in use", 32'hFFFF_FFFF, rogue_crc)
    $display("test parameter ranges done");
    exp_pos = master_position;
    // rows 0..3 carry an out-of-range preset so that trigger is refused
    for (i = 0; i < 9; i++)
    begin
      rogue.safety_preset_value = (i < 4) ? measuring_range : 32'h0000_1234;
      rogue.safety_control_word = t_ctl[i];
      step(4);
      if (i == 6)
        exp_pos = 32'h0000_1234;
      `CHECK("rogue status", t_sts[i], rogue.safety_status_word)
      `CHECK("rogue position", exp_pos, rogue.safety_position_32)
    end
    $display("test handshake table done");
    host_param(16'h0009, 16'h0000, 8'h00, 8'h01, 1'b0);
    host_param(16'h01F4, 16'h0010, 8'h20, 8'h00, 1'b1);
    `CHECK("watchdog in use", 16'h01F4, watchdog_ms)
    `CHECK("cyclic exchange", 1'b1, link.cyclic_exchange)
    run_preset(32'h0000_ABCD, 1'b0);
    `CHECK("host position", 32'h0000_ABCD, link.safety_position_32)
    preset_enable = 1'b0;
    run_preset(32'h0000_0123, 1'b1);
    `CHECK("kept position", 32'h0000_ABCD, link.safety_position_32)
    preset_enable = 1'b1;
    $display("test host preset done");
    for (i = 0; i < 3; i++)
    begin
      {fault_safety_only, fault_shared, fault_standard_only} = 3'h4 >> i;
      step(2);
      `CHECK("safety alarm", (i < 2) ? relation_active : 4'h0, safety_alarm)
      `CHECK("standard alarm", 1'(i > 0), standard_alarm)
    end
    {fault_safety_only, fault_shared, fault_standard_only} = 3'h0;
    slave_position = 32'h0000_5000 + 32'h0000_03E8;
    step(3);
    `CHECK("deviation at limit", 1'b0, deviation_fault)
    slave_position = 32'h0000_5000 - 32'h0000_03E9;
    step(3);
    `CHECK("deviation over limit", 1'b1, deviation_fault)
    `CHECK("deviation alarm", relation_active, safety_alarm)
    $display("test diagnostics done");
    end_of_test();
  end
  initial
  begin
    #200000;
    fails++;
    end_of_test();
  end
endmodule
